// file: dv/avm_host_model.sv
// Host model that reaches the detector registers through its byte access port.
`timescale 1ns/100ps
module avm_host_model
(
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // The strobes start low and the idle lines start from a known pattern.
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Idle address and data are inverted, so a stale value never passes for a live one.
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // One write strobe for one clock, launched just after a rising edge.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    release_bus();
  endtask

  // One read strobe; the registered data is taken once the taking edge has landed.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    data = reg_rdata;
    release_bus();
  endtask
endmodule // avm_host_model

// file: dv/test_accel_vector_magnitude_detect.sv
// Self-checking testbench for the vector-magnitude change detector.
`timescale 1ns/100ps
module test_accel_vector_magnitude_detect;
  import avm_pkg::*;
  logic clock;
  logic nrst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sample_valid;
  logic signed [AVM_AXIS_W-1:0] accel_x;
  logic signed [AVM_AXIS_W-1:0] accel_y;
  logic signed [AVM_AXIS_W-1:0] accel_z;
  logic vecm_enable;
  logic ref_from_regs;
  logic ref_hold;
  logic latch_enable;
  logic hybrid_mode;
  logic vecm_event;
  int failures;
  int comparisons;
  logic [7:0] exp_val;
  logic [7:0] prog [9] = '{8'h01, 8'h05, 8'h02, 8'h3f, 8'h9c, 8'h00, 8'h32, 8'h00, 8'h00};

  avm_top uut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .vecm_enable(vecm_enable),
    .ref_from_regs(ref_from_regs), .ref_hold(ref_hold), .latch_enable(latch_enable),
    .hybrid_mode(hybrid_mode), .vecm_event(vecm_event));

  avm_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // Free-running 50 MHz clock.
  always #10 clock = ~clock;

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one value with case equality and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reads one register and compares it with the expected byte.
  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    host.read_reg(addr, got);
    check($sformatf("register %h", addr), exp, got);
  endtask

  // Sets the mode inputs with the function off, then enables it on the given sample.
  task automatic arm(input logic src, input logic hold, input logic lat, input logic hyb,
    input int x, input int y, input int z);
    @(posedge clock);
    #1;
    vecm_enable = 1'b0;
    ref_from_regs = src;
    ref_hold = hold;
    latch_enable = lat;
    hybrid_mode = hyb;
    accel_x = AVM_AXIS_W'(x);
    accel_y = AVM_AXIS_W'(y);
    accel_z = AVM_AXIS_W'(z);
    @(posedge clock);
    #1;
    vecm_enable = 1'b1;
    @(posedge clock);
  endtask

  // Presents one output sample for one clock, then checks the settled event flag.
  task automatic step(input int x, input int y, input int z, input logic exp_evt);
    @(posedge clock);
    #1;
    accel_x = AVM_AXIS_W'(x);
    accel_y = AVM_AXIS_W'(y);
    accel_z = AVM_AXIS_W'(z);
    sample_valid = 1'b1;
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("event", {7'h00, exp_evt}, {7'h00, vecm_event});
  endtask

  // Main sequence: reset, register map, then the detection scenarios.
  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    sample_valid = 1'b0;
    accel_x = '0;
    accel_y = '0;
    accel_z = '0;
    vecm_enable = 1'b0;
    ref_from_regs = 1'b0;
    ref_hold = 1'b0;
    latch_enable = 1'b0;
    hybrid_mode = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    #1;
    nrst = 1'b1;
    for (int a = 8'h60; a <= 8'h68; a++)
      check_reg(8'(a), 8'h00);
    check_reg(AVM_ADDR_INT_SRC, 8'h00);
    // All ones into every byte; reserved bits must read back as zero.
    for (int a = 8'h60; a <= 8'h68; a++)
    begin
      host.write_reg(8'(a), 8'hff);
      exp_val = (a == 8'h60) ? 8'h9f : (a == 8'h63 || a == 8'h65 || a == 8'h67) ? 8'h3f : 8'hff;
      check_reg(8'(a), exp_val);
    end
    host.write_reg(8'h69, 8'hff);
    host.write_reg(AVM_ADDR_INT_SRC, 8'hff);
    check_reg(8'h69, 8'h00);
    check_reg(8'h5f, 8'h00);
    check_reg(AVM_ADDR_INT_SRC, 8'h00);
    // Threshold 261, count 2, references x=-100, y=50, z=0.
    for (int i = 0; i < 9; i++)
      host.write_reg(8'(8'h60 + i), prog[i]);
    arm(1'b1, 1'b1, 1'b0, 1'b0, 0, 0, 0);
    step(161, 50, 0, 1'b0);
    step(-100, 312, 0, 1'b0);
    step(-100, 50, 262, 1'b1);
    step(-100, 50, 0, 1'b0);
    step(162, 50, 0, 1'b1);
    step(162, 50, 0, 1'b1);
    step(-100, 50, 0, 1'b0);
    step(-100, 50, 0, 1'b0);
    step(162, 50, 0, 1'b0);
    // Clear mode: one drop empties the counter.
    host.write_reg(AVM_ADDR_THS_HI, 8'h81);
    step(162, 50, 0, 1'b1);
    step(-100, 50, 0, 1'b0);
    step(162, 50, 0, 1'b0);
    // Reference from the enabling sample, replaced on each trigger.
    host.write_reg(AVM_ADDR_CNT, 8'h00);
    arm(1'b0, 1'b0, 1'b0, 1'b0, 500, 0, 0);
    step(762, 0, 0, 1'b1);
    step(762, 0, 0, 1'b0);
    // Latched flag holds until the source byte is read.
    arm(1'b1, 1'b1, 1'b1, 1'b0, 0, 0, 0);
    step(162, 50, 0, 1'b1);
    step(-100, 50, 0, 1'b1);
    check_reg(AVM_ADDR_INT_SRC, 8'h02);
    check("event", 8'h00, {7'h00, vecm_event});
    check_reg(AVM_ADDR_INT_SRC, 8'h00);
    // Count 1: hybrid mode needs two samples, normal mode one.
    host.write_reg(AVM_ADDR_CNT, 8'h01);
    arm(1'b1, 1'b1, 1'b0, 1'b1, 0, 0, 0);
    step(162, 50, 0, 1'b0);
    step(162, 50, 0, 1'b1);
    arm(1'b1, 1'b1, 1'b0, 1'b0, 0, 0, 0);
    step(162, 50, 0, 1'b1);
    // Enable-time references kept or replaced by the update bit.
    host.write_reg(AVM_ADDR_CNT, 8'h00);
    arm(1'b0, 1'b1, 1'b0, 1'b0, 500, 0, 0);
    step(762, 0, 0, 1'b1);
    step(762, 0, 0, 1'b1);
    arm(1'b1, 1'b0, 1'b0, 1'b0, 0, 0, 0);
    host.write_reg(AVM_ADDR_INITX_LO, 8'h00);
    step(-362, 50, 0, 1'b1);
    step(-362, 50, 0, 1'b0);
    vecm_enable = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("event", 8'h00, {7'h00, vecm_event});
    complete_run();
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end
endmodule // test_accel_vector_magnitude_detect

// file: src/avm_cfg_if.sv
// Configuration fields passed from the register bank to the detector core.
`timescale 1ns/100ps
interface avm_cfg_if;
  import avm_pkg::*;
  logic [AVM_THS_W-1:0] ths;
  logic dbcntm;
  logic [AVM_CNT_W-1:0] cnt;
  logic signed [AVM_AXIS_W-1:0] init_x;
  logic signed [AVM_AXIS_W-1:0] init_y;
  logic signed [AVM_AXIS_W-1:0] init_z;
  modport regs (output ths, output dbcntm, output cnt, output init_x, output init_y,
    output init_z);
  modport core (input ths, input dbcntm, input cnt, input init_x, input init_y,
    input init_z);
endinterface

// file: src/avm_dist.sv
// Squared-distance comparator between a sample and the reference vector.
`timescale 1ns/100ps
module avm_dist
  import avm_pkg::*;
#(
  parameter int AXIS_W = AVM_AXIS_W,
  parameter int THS_W = AVM_THS_W
)
(
  input wire logic signed [AXIS_W-1:0] smp_x,
  input wire logic signed [AXIS_W-1:0] smp_y,
  input wire logic signed [AXIS_W-1:0] smp_z,
  input wire logic signed [AXIS_W-1:0] ref_x,
  input wire logic signed [AXIS_W-1:0] ref_y,
  input wire logic signed [AXIS_W-1:0] ref_z,
  input wire logic [THS_W-1:0] ths,
  output logic over
);

  localparam int DW = AXIS_W + 1;
  localparam int SW = 2 * DW;
  localparam int TW = SW + 2;

  logic signed [DW-1:0] dx;
  logic signed [DW-1:0] dy;
  logic signed [DW-1:0] dz;
  logic [TW-1:0] sum;
  logic [TW-1:0] ths_sq;

  // Square of a signed difference, exact in twice the width.
  function automatic logic [SW-1:0] avm_sq(input logic signed [DW-1:0] d);
    logic signed [SW-1:0] w;
    w = SW'(d);
    avm_sq = SW'(w * w);
  endfunction

  // Comparing squares avoids a root; sample and threshold share one LSB
  // weight at the selected full scale, so no rescaling is needed.
  assign dx = DW'(smp_x) - DW'(ref_x);
  assign dy = DW'(smp_y) - DW'(ref_y);
  assign dz = DW'(smp_z) - DW'(ref_z);
  assign sum = TW'(avm_sq(dx)) + TW'(avm_sq(dy)) + TW'(avm_sq(dz));
  assign ths_sq = TW'(TW'(ths) * TW'(ths));
  assign over = sum > ths_sq;

endmodule // avm_dist

// file: src/avm_pkg.sv
// Constants shared by the accelerometer vector-magnitude detector files.
package avm_pkg;

  // Data widths of the sample path.
  localparam int AVM_AXIS_W = 14;
  localparam int AVM_THS_W = 13;
  localparam int AVM_CNT_W = 8;
  localparam int AVM_BYTE_W = 8;

  // Register byte addresses.
  localparam logic [7:0] AVM_ADDR_THS_HI = 8'h60;
  localparam logic [7:0] AVM_ADDR_THS_LO = 8'h61;
  localparam logic [7:0] AVM_ADDR_CNT = 8'h62;
  localparam logic [7:0] AVM_ADDR_INITX_HI = 8'h63;
  localparam logic [7:0] AVM_ADDR_INITX_LO = 8'h64;
  localparam logic [7:0] AVM_ADDR_INITY_HI = 8'h65;
  localparam logic [7:0] AVM_ADDR_INITY_LO = 8'h66;
  localparam logic [7:0] AVM_ADDR_INITZ_HI = 8'h67;
  localparam logic [7:0] AVM_ADDR_INITZ_LO = 8'h68;
  localparam logic [7:0] AVM_ADDR_INT_SRC = 8'h0C;

  // Register bank layout: nine bytes from the threshold high byte upward.
  localparam logic [7:0] AVM_REG_BASE = AVM_ADDR_THS_HI;
  localparam int AVM_REG_NUM = 9;
  localparam int AVM_IDX_W = 4;
  localparam logic [7:0] AVM_RESET_BYTE = 8'h00;

  // Field layout inside the bytes.
  localparam int AVM_DBCNTM_BIT = 7;
  localparam int AVM_THS_HI_W = 5;
  localparam int AVM_INIT_HI_W = 6;
  localparam logic [7:0] AVM_THS_HI_MASK = 8'h9F;
  localparam logic [7:0] AVM_INIT_HI_MASK = 8'h3F;
  localparam logic [7:0] AVM_FULL_MASK = 8'hFF;

  // Bit of the interrupt source byte that reports this event.
  localparam int AVM_SRC_VECM_BIT = 1;

  // Counter step and empty value.
  localparam logic [7:0] AVM_CNT_ONE = 8'h01;
  localparam logic [7:0] AVM_CNT_ZERO = 8'h00;

endpackage

// file: src/avm_regs.sv
// Register bank holding threshold, debounce count and initial reference bytes.
`timescale 1ns/100ps
module avm_regs
  import avm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rd_data,
  avm_cfg_if.regs cfg
);

  typedef struct packed {
    logic [AVM_REG_NUM-1:0][AVM_BYTE_W-1:0] bytes;
  } avm_regs_s;

  avm_regs_s st;
  avm_regs_s next_st;
  logic [AVM_IDX_W-1:0] idx;
  logic hit;

  // Bank index of a register byte address.
  function automatic logic [AVM_IDX_W-1:0] avm_idx(input logic [7:0] a);
    avm_idx = AVM_IDX_W'(a - AVM_REG_BASE);
  endfunction

  // Writable bits of each byte; reserved bits stay zero.
  function automatic logic [7:0] avm_mask(input logic [AVM_IDX_W-1:0] i);
    case (i)
      AVM_IDX_W'(AVM_ADDR_THS_HI - AVM_REG_BASE): avm_mask = AVM_THS_HI_MASK;
      AVM_IDX_W'(AVM_ADDR_INITX_HI - AVM_REG_BASE): avm_mask = AVM_INIT_HI_MASK;
      AVM_IDX_W'(AVM_ADDR_INITY_HI - AVM_REG_BASE): avm_mask = AVM_INIT_HI_MASK;
      AVM_IDX_W'(AVM_ADDR_INITZ_HI - AVM_REG_BASE): avm_mask = AVM_INIT_HI_MASK;
      default: avm_mask = AVM_FULL_MASK;
    endcase
  endfunction

  // Address decode of the bank.
  assign idx = avm_idx(addr);
  assign hit = (addr >= AVM_REG_BASE) && (addr < AVM_REG_BASE + 8'(AVM_REG_NUM));

  // Byte writes and read mux; unmapped addresses read as zero.
  always_comb
  begin
    next_st = st;
    if (wr_en && hit)
    begin
      next_st.bytes[idx] = wdata & avm_mask(idx);
    end
    rd_data = hit ? st.bytes[idx] : AVM_RESET_BYTE;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '{default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // Fields assembled from high and low bytes.
  assign cfg.ths = {st.bytes[avm_idx(AVM_ADDR_THS_HI)][AVM_THS_HI_W-1:0],
    st.bytes[avm_idx(AVM_ADDR_THS_LO)]};
  assign cfg.dbcntm = st.bytes[avm_idx(AVM_ADDR_THS_HI)][AVM_DBCNTM_BIT];
  assign cfg.cnt = st.bytes[avm_idx(AVM_ADDR_CNT)];
  assign cfg.init_x = {st.bytes[avm_idx(AVM_ADDR_INITX_HI)][AVM_INIT_HI_W-1:0],
    st.bytes[avm_idx(AVM_ADDR_INITX_LO)]};
  assign cfg.init_y = {st.bytes[avm_idx(AVM_ADDR_INITY_HI)][AVM_INIT_HI_W-1:0],
    st.bytes[avm_idx(AVM_ADDR_INITY_LO)]};
  assign cfg.init_z = {st.bytes[avm_idx(AVM_ADDR_INITZ_HI)][AVM_INIT_HI_W-1:0],
    st.bytes[avm_idx(AVM_ADDR_INITZ_LO)]};

endmodule // avm_regs

// file: src/avm_top.sv
// Accelerometer vector-magnitude change detector with debounce and latching.
//
// Function
// - With debounce mode 0, a sample below threshold steps the counter down by one.
// - With debounce mode 1, a sample below threshold clears the counter at once.
// - The threshold is 13 bits, five high bits in 0x60 beside mode bit 7, low byte in 0x61.
// - One threshold count weighs one output LSB at the selected full scale.
// - Register 0x62 holds the 8-bit debounce count.
// - Outside hybrid mode the counter steps once per output sample, so the period is count times 1/ODR.
// - In hybrid mode the counter steps on every second sample only.
// - A 14-bit signed X reference sits in 0x63/0x64 and is used when the source bit selects it.
// - A 14-bit signed Y reference sits in 0x65/0x66 and is used when the source bit selects it.
// - A 14-bit signed Z reference sits in 0x67/0x68 and is used when the source bit selects it.
// - The event rises when the distance to the reference exceeds the threshold long enough.
// - On enable the reference loads from the current sample or from the registers.
// - With update bit 0 the reference takes the sample on each trigger; with 1 it is kept, but with the source bit also set the registers are used live.
// - Unlatched the flag follows the condition; latched it holds until 0x0C is read.
`timescale 1ns/100ps
module avm_top
  import avm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic signed [AVM_AXIS_W-1:0] accel_x,
  input wire logic signed [AVM_AXIS_W-1:0] accel_y,
  input wire logic signed [AVM_AXIS_W-1:0] accel_z,
  input wire logic vecm_enable,
  input wire logic ref_from_regs,
  input wire logic ref_hold,
  input wire logic latch_enable,
  input wire logic hybrid_mode,
  output logic vecm_event
);

  typedef struct packed {
    logic [AVM_CNT_W-1:0] cnt;
    logic signed [AVM_AXIS_W-1:0] ref_x;
    logic signed [AVM_AXIS_W-1:0] ref_y;
    logic signed [AVM_AXIS_W-1:0] ref_z;
    logic running;
    logic hyb_phase;
    logic active;
    logic flag;
    logic [7:0] rdata;
  } avm_core_s;

  avm_core_s st;
  avm_core_s next_st;

  avm_cfg_if cfg ();

  logic [7:0] bank_rdata;
  logic over;
  logic start;
  logic step;
  logic run_step;
  logic trig;
  logic src_read;
  logic live_init;
  logic [AVM_CNT_W-1:0] cnt_up;
  logic [AVM_CNT_W-1:0] cnt_down;
  logic [AVM_CNT_W-1:0] cnt_step;
  logic signed [AVM_AXIS_W-1:0] use_x;
  logic signed [AVM_AXIS_W-1:0] use_y;
  logic signed [AVM_AXIS_W-1:0] use_z;
  logic [7:0] src_byte;

  // Register bank behind the byte-wide register port.
  avm_regs u_regs (
    .clock(clock),
    .nrst(nrst),
    .wr_en(reg_wr),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .rd_data(bank_rdata),
    .cfg(cfg)
  );

  // With both source and hold set, software steers the reference live.
  assign live_init = ref_from_regs && ref_hold;
  assign use_x = live_init ? cfg.init_x : st.ref_x;
  assign use_y = live_init ? cfg.init_y : st.ref_y;
  assign use_z = live_init ? cfg.init_z : st.ref_z;

  // Distance test of the current sample against the reference.
  avm_dist #(
    .AXIS_W(AVM_AXIS_W),
    .THS_W(AVM_THS_W)
  ) u_dist (
    .smp_x(accel_x),
    .smp_y(accel_y),
    .smp_z(accel_z),
    .ref_x(use_x),
    .ref_y(use_y),
    .ref_z(use_z),
    .ths(cfg.ths),
    .over(over)
  );

  // Sample stepping; hybrid mode skips every other sample.
  assign start = vecm_enable && !st.running;
  assign step = sample_valid && (!hybrid_mode || st.hyb_phase);
  // A sample that lands in the disabling cycle is ignored.
  assign run_step = step && st.running && vecm_enable;

  // Saturating counter candidates for both outcomes of a sample.
  assign cnt_up = (st.cnt >= cfg.cnt) ? cfg.cnt : AVM_CNT_W'(st.cnt + AVM_CNT_ONE);
  assign cnt_down = (cfg.dbcntm || st.cnt == AVM_CNT_ZERO) ? AVM_CNT_ZERO
    : AVM_CNT_W'(st.cnt - AVM_CNT_ONE);
  assign cnt_step = over ? cnt_up : cnt_down;
  assign trig = run_step && over && (cnt_up == cfg.cnt);
  assign src_read = reg_rd && (reg_addr == AVM_ADDR_INT_SRC);

  // Next state of the detector.
  always_comb
  begin
    next_st = st;
    src_byte = AVM_RESET_BYTE;
    src_byte[AVM_SRC_VECM_BIT] = st.flag;
    if (!vecm_enable)
    begin
      next_st.running = 1'b0;
      next_st.cnt = AVM_CNT_ZERO;
      next_st.active = 1'b0;
      next_st.hyb_phase = 1'b0;
    end
    else if (start)
    begin
      // Reference taken at enable from sample or registers.
      next_st.running = 1'b1;
      next_st.cnt = AVM_CNT_ZERO;
      next_st.active = 1'b0;
      next_st.ref_x = ref_from_regs ? cfg.init_x : accel_x;
      next_st.ref_y = ref_from_regs ? cfg.init_y : accel_y;
      next_st.ref_z = ref_from_regs ? cfg.init_z : accel_z;
    end
    else
    begin
      if (sample_valid)
      begin
        next_st.hyb_phase = hybrid_mode && !st.hyb_phase;
      end
      if (run_step)
      begin
        next_st.cnt = cnt_step;
        next_st.active = trig;
      end
      if (trig && !ref_hold)
      begin
        next_st.ref_x = accel_x;
        next_st.ref_y = accel_y;
        next_st.ref_z = accel_z;
      end
    end
    // A trigger in the cycle of the source read keeps the flag set.
    if (latch_enable)
    begin
      next_st.flag = trig || (st.flag && !src_read);
    end
    else
    begin
      next_st.flag = next_st.active;
    end
    if (reg_rd)
    begin
      next_st.rdata = src_read ? src_byte : bank_rdata;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '{default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign reg_rdata = st.rdata;
  assign vecm_event = st.flag;

  // Decrement mode lowers a nonzero counter by exactly one.
  dec_mode_a: assert property (@(posedge clock) disable iff (!nrst)
    run_step && !over && !cfg.dbcntm && st.cnt != AVM_CNT_ZERO && vecm_enable
    |=> st.cnt == $past(st.cnt) - AVM_CNT_ONE)
    else $error("counter did not decrement by one");

  // Clear mode empties the counter on a low sample.
  clr_mode_a: assert property (@(posedge clock) disable iff (!nrst)
    run_step && !over && cfg.dbcntm && vecm_enable |=> st.cnt == AVM_CNT_ZERO)
    else $error("counter not cleared in clear mode");

  // Threshold low byte write reaches the comparator.
  ths_low_a: assert property (@(posedge clock) disable iff (!nrst)
    reg_wr && reg_addr == AVM_ADDR_THS_LO |=> cfg.ths[7:0] == $past(reg_wdata))
    else $error("threshold low byte not stored");

  // Count register write takes effect one cycle later.
  cnt_reg_a: assert property (@(posedge clock) disable iff (!nrst)
    reg_wr && reg_addr == AVM_ADDR_CNT |=> cfg.cnt == $past(reg_wdata))
    else $error("debounce count not stored");

  // Counter holds between sample steps.
  cnt_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !step && st.running && vecm_enable |=> st.cnt == $past(st.cnt))
    else $error("counter moved without a sample step");

  // Hybrid mode never steps on two samples in a row.
  hyb_skip_a: assert property (@(posedge clock) disable iff (!nrst)
    hybrid_mode && step ##1 hybrid_mode && sample_valid |-> !step)
    else $error("hybrid mode stepped on consecutive samples");

  // Registers loaded at enable become the stored reference.
  init_ref_a: assert property (@(posedge clock) disable iff (!nrst)
    start && ref_from_regs |=> st.ref_x == $past(cfg.init_x) && st.ref_y == $past(cfg.init_y)
    && st.ref_z == $past(cfg.init_z))
    else $error("reference not loaded from registers at enable");

  // Reaching the count raises the event next cycle.
  event_set_a: assert property (@(posedge clock) disable iff (!nrst)
    trig |=> vecm_event)
    else $error("event not raised on reaching the count");

  // Enable with sample source loads the present X and Z sample into the reference.
  ref_load_a: assert property (@(posedge clock) disable iff (!nrst)
    start && !ref_from_regs |=> st.ref_x == $past(accel_x) && st.ref_z == $past(accel_z))
    else $error("reference not loaded from sample at enable");

  // Update mode copies the sample Y into the reference on a trigger.
  ref_upd_a: assert property (@(posedge clock) disable iff (!nrst)
    trig && !ref_hold && vecm_enable |=> st.ref_y == $past(accel_y))
    else $error("reference not updated on trigger");

  // Latched flag survives until the source byte is read.
  latch_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    latch_enable && vecm_event && !src_read |=> vecm_event)
    else $error("latched flag dropped without a read");

  // Unlatched flag drops on a sample below threshold.
  live_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    !latch_enable && run_step && !over && vecm_enable |=> !vecm_event)
    else $error("unlatched flag did not follow the condition");

  // Counter never passes the programmed count when rising.
  cnt_sat_a: assert property (@(posedge clock) disable iff (!nrst)
    run_step && over && vecm_enable |=> st.cnt <= $past(cfg.cnt))
    else $error("counter exceeded the programmed count");

  // A source read clears the latched flag unless a trigger lands with it.
  flag_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    latch_enable && src_read && !trig |=> !vecm_event)
    else $error("latched flag not cleared by the source read");

  // The source byte returns the flag as it stood at the read.
  src_byte_a: assert property (@(posedge clock) disable iff (!nrst)
    src_read |=> reg_rdata[AVM_SRC_VECM_BIT] == $past(vecm_event))
    else $error("source byte does not report the flag");

  // Hold mode never moves the stored reference after enable.
  ref_keep_a: assert property (@(posedge clock) disable iff (!nrst)
    ref_hold && !start |=> $stable(st.ref_x) && $stable(st.ref_y) && $stable(st.ref_z))
    else $error("reference moved in hold mode");

  // Disabling empties the counter and stops the detector.
  idle_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    !vecm_enable |=> st.cnt == AVM_CNT_ZERO && !st.running)
    else $error("counter not cleared while disabled");

  // In hybrid mode the phase flips on every sample while running.
  hyb_toggle_a: assert property (@(posedge clock) disable iff (!nrst)
    st.running && vecm_enable && hybrid_mode && sample_valid
    |=> st.hyb_phase != $past(st.hyb_phase))
    else $error("hybrid phase did not flip on a sample");

  // A zero count lets any step over threshold trigger.
  cnt_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    run_step && over && cfg.cnt == AVM_CNT_ZERO |-> trig)
    else $error("zero count did not trigger at once");

endmodule // avm_top
